//--- gsq_cfg.svh
// Offsets, field values, reset values and timing counts of the reset and init sequencer
`ifndef GSQ_CFG_SVH
`define GSQ_CFG_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define GSQ_CLK_MHZ 100

// ----------------------------------------
// Register offsets and values
// ----------------------------------------
`define GSQ_OFS_LEVEL 8'h0d
`define GSQ_OFS_PROFILE 8'h12
`define GSQ_OFS_PWRMODE 8'h15
`define GSQ_PWR_OPER 16'h0001
`define GSQ_PWR_SLEEP 16'h0002
`define GSQ_PROFILE_RST 16'h0000
`define GSQ_RDATA_NONE 16'h0000
`define GSQ_LEVEL_MAX 7'h64

// ----------------------------------------
// Timing (times in microseconds, counts in cycles)
// ----------------------------------------
`define GSQ_INIT_TIME_US 100
`define GSQ_INIT_CYC (`GSQ_INIT_TIME_US * `GSQ_CLK_MHZ)
`define GSQ_SLEEP_TIME_US 1000
`define GSQ_SLEEP_CYC (`GSQ_SLEEP_TIME_US * `GSQ_CLK_MHZ)
`define GSQ_FAST_TIME_US 10
`define GSQ_FAST_CYC (`GSQ_FAST_TIME_US * `GSQ_CLK_MHZ)
`define GSQ_SLOW_TIME_US 160
`define GSQ_SLOW_CYC (`GSQ_SLOW_TIME_US * `GSQ_CLK_MHZ)

// ----------------------------------------
// Tracker constants
// ----------------------------------------
`define GSQ_DELTA_TH 17'h00040
`define GSQ_CHG_UNIT 24'h004000
`define GSQ_CONV_TICKS 8'h20

`endif

//--- gsq_pkg.sv
// Types shared by the reset and init sequencer
package gsq_pkg;
	typedef enum logic [3:0] {
		ST_RESET = 4'b0001,
		ST_INIT = 4'b0010,
		ST_OPER = 4'b0100,
		ST_SLEEP = 4'b1000
	} gsq_state_e;
	typedef logic [15:0] gsq_word_t;
endpackage

//--- gsq_tracker.sv
// Adaptive sampling and self-converging charge level tracker
`include "gsq_cfg.svh"
module gsq_tracker #(
	parameter int FAST_CYC = `GSQ_FAST_CYC,
	parameter int SLOW_CYC = `GSQ_SLOW_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Control
	input wire logic run_i,
	input wire logic clr_i,
	// Measurements
	input wire logic signed [15:0] current_i,
	input wire logic [6:0] ocv_level_i,
	// Results
	output logic [6:0] level_o,
	output logic sample_o
);
	localparam int CW = $clog2(SLOW_CYC + 1);

	logic [CW-1:0] cnt_q, cnt_d;
	logic signed [15:0] last_q, last_d;
	logic signed [23:0] acc_q, acc_d;
	logic [7:0] conv_q, conv_d;
	logic [6:0] level_q, level_d;
	logic fast_q, fast_d;
	logic tick_q, tick_d;

	always_comb begin
		logic signed [16:0] diff;
		logic [CW-1:0] limit;
		diff = 17'(current_i) - 17'(last_q);
		limit = fast_q ? CW'(FAST_CYC - 1) : CW'(SLOW_CYC - 1);
		cnt_d = cnt_q;
		last_d = last_q;
		acc_d = acc_q;
		conv_d = conv_q;
		level_d = level_q;
		fast_d = fast_q;
		tick_d = 1'b0;
		if (clr_i) begin
			cnt_d = '0;
			acc_d = '0;
			conv_d = '0;
			level_d = (ocv_level_i > `GSQ_LEVEL_MAX) ? `GSQ_LEVEL_MAX : ocv_level_i;
		end else if (run_i) begin
			if (cnt_q >= limit) begin
				cnt_d = '0;
				tick_d = 1'b1;
				last_d = current_i;
				// A current swing shortens the interval, a steady cell stretches it. see [RQ9]
				// Signed on both sides, or a steady cell would read as a swing
				fast_d = (diff > $signed(`GSQ_DELTA_TH)) || (diff < -$signed(`GSQ_DELTA_TH));
				acc_d = acc_q + 24'(current_i);
				if (acc_d >= $signed(`GSQ_CHG_UNIT)) begin
					acc_d = acc_d - $signed(`GSQ_CHG_UNIT);
					if (level_q < `GSQ_LEVEL_MAX) level_d = level_q + 7'h01;
				end else if (acc_d <= -$signed(`GSQ_CHG_UNIT)) begin
					acc_d = acc_d + $signed(`GSQ_CHG_UNIT);
					if (level_q != 7'h00) level_d = level_q - 7'h01;
				end
				// Counting error is pulled one step toward the open-circuit estimate. see [RQ10]
				conv_d = conv_q + 8'h01;
				if (conv_q == `GSQ_CONV_TICKS - 8'h01) begin
					conv_d = '0;
					if (ocv_level_i > level_d && level_d < `GSQ_LEVEL_MAX) begin
						level_d = level_d + 7'h01;
					end else if (ocv_level_i < level_d) begin
						level_d = level_d - 7'h01;
					end
				end
			end else begin
				cnt_d = cnt_q + CW'(1);
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_q <= '0;
			last_q <= '0;
			acc_q <= '0;
			conv_q <= '0;
			level_q <= '0;
			fast_q <= 1'b0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			last_q <= last_d;
			acc_q <= acc_d;
			conv_q <= conv_d;
			level_q <= level_d;
			fast_q <= fast_d;
			tick_q <= tick_d;
		end
	end

	assign level_o = level_q;
	assign sample_o = tick_q;
endmodule // gsq_tracker

//--- gsq_sequencer.sv
// Power-on reset and initialization sequencer of a single-cell gauge
// Summary of operation
// [RQ1] Battery insertion starts power-on reset by itself.
// [RQ2] Above release voltage, leave reset, init within bounded time, go operational.
// [RQ3] Power-on reset restores register defaults before host access is accepted.
// [RQ4] Auto-sleep variant enters sleep after the auto-sleep delay following init.
// [RQ5] Other variant stays operational and never sleeps by itself.
// [RQ6] Auto-sleep variant: host writes operational mode after the device sleeps.
// [RQ7] Cell voltage below release threshold while running forces full reset.
// [RQ8] Writing the profile-select register re-runs the insertion init sequence.
// [RQ9] Operational mode adapts sampling rate to changes in cell current.
// [RQ10] Charge level converges toward the open-circuit estimate without calibration.
// [RQ11] Power-mode register: 02 is sleep, 01 is operational; host writes it.
// [RQ12] Sleep keeps only the register interface, measurement and tracking stop.
// [RQ13] Host waits out the init time before issuing transactions.
`include "gsq_cfg.svh"
module gsq_sequencer #(
	parameter bit AUTO_SLEEP = 1'b1,
	parameter int INIT_CYC = `GSQ_INIT_CYC,
	parameter int SLEEP_CYC = `GSQ_SLEEP_CYC,
	parameter int FAST_CYC = `GSQ_FAST_CYC,
	parameter int SLOW_CYC = `GSQ_SLOW_CYC
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic NRST_I,
	// Cell sensing, asynchronous to CLK_I
	input wire logic BATT_DET_I,
	input wire logic CELL_ABOVE_RR_I,
	// Measurement front end, on CLK_I
	input wire logic signed [15:0] CELL_CURRENT_I,
	input wire logic [6:0] OCV_LEVEL_I,
	// Register access from the serial interface
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [15:0] REG_WDATA_I,
	output logic REG_READY_O,
	output logic REG_RVALID_O,
	output logic [15:0] REG_RDATA_O,
	// Status
	output logic IN_RESET_O,
	output logic INIT_BUSY_O,
	output logic OPER_O,
	output logic SLEEP_O,
	output logic SAMPLE_O,
	output logic [6:0] CHARGE_LEVEL_O,
	output logic [15:0] PROFILE_O
);
	localparam int TW = $clog2((INIT_CYC > SLEEP_CYC ? INIT_CYC : SLEEP_CYC) + 1);
	localparam int INIT_LIMIT = INIT_CYC;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [1:0] raw;
	logic [1:0] s1_q, s2_q, s3_q, stab_q, stab_d;
	assign raw = {CELL_ABOVE_RR_I, BATT_DET_I};

	for (genvar i = 0; i < 2; i++) begin : g_sync
		// Glitches shorter than one cycle are dropped: s2 and s3 must agree.
		assign stab_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stab_q[i];
		always_ff @(posedge CLK_I or negedge NRST_I) begin
			if (!NRST_I) begin
				s1_q[i] <= 1'b0;
				s2_q[i] <= 1'b0;
				s3_q[i] <= 1'b0;
				stab_q[i] <= 1'b0;
			end else begin
				s1_q[i] <= raw[i];
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
				stab_q[i] <= stab_d[i];
			end
		end
	end

	logic present, above, insert;
	assign present = stab_q[0];
	assign above = stab_q[1];
	assign insert = stab_d[0] & ~stab_q[0];

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	gsq_pkg::gsq_state_e state_q, state_d;
	logic [TW-1:0] tmr_q, tmr_d;
	logic armed_q, armed_d;
	gsq_pkg::gsq_word_t profile_q, profile_d;
	logic ready, brown, wr_ok, wr_prof, wr_pwr;

	assign ready = (state_q == gsq_pkg::ST_OPER) || (state_q == gsq_pkg::ST_SLEEP);
	assign brown = (state_q != gsq_pkg::ST_RESET) && (!above || !present || insert);
	assign wr_ok = REG_WR_I && ready && !brown;
	assign wr_prof = wr_ok && (REG_ADDR_I == `GSQ_OFS_PROFILE);
	assign wr_pwr = wr_ok && (REG_ADDR_I == `GSQ_OFS_PWRMODE);

	always_comb begin
		state_d = state_q;
		tmr_d = tmr_q;
		armed_d = armed_q;
		profile_d = profile_q;
		case (state_q)
			gsq_pkg::ST_RESET: begin
				// Defaults are loaded here, and the host is kept out until init ends. see [RQ3]
				profile_d = `GSQ_PROFILE_RST;
				armed_d = 1'b0;
				tmr_d = '0;
				if (present && above && !insert) begin
					state_d = gsq_pkg::ST_INIT; // see [RQ2]
				end
			end
			gsq_pkg::ST_INIT: begin
				if (tmr_q >= TW'(INIT_CYC - 1)) begin
					state_d = gsq_pkg::ST_OPER; // see [RQ2]
					tmr_d = '0;
					armed_d = AUTO_SLEEP; // see [RQ5]
				end else begin
					tmr_d = tmr_q + TW'(1);
				end
			end
			gsq_pkg::ST_OPER: begin
				if (armed_q) begin
					if (tmr_q >= TW'(SLEEP_CYC - 1)) begin
						state_d = gsq_pkg::ST_SLEEP; // see [RQ4]
						armed_d = 1'b0;
					end else begin
						tmr_d = tmr_q + TW'(1);
					end
				end
			end
			gsq_pkg::ST_SLEEP: begin
				// Leaving sleep relies on the host writing the operational code. see [RQ6]
			end
			default: state_d = gsq_pkg::ST_RESET;
		endcase
		if (wr_pwr) begin
			// Any mode write ends the automatic sleep countdown. see [RQ11]
			armed_d = 1'b0;
			if (REG_WDATA_I == `GSQ_PWR_OPER) state_d = gsq_pkg::ST_OPER;
			else if (REG_WDATA_I == `GSQ_PWR_SLEEP) state_d = gsq_pkg::ST_SLEEP;
		end
		if (wr_prof) begin
			profile_d = REG_WDATA_I;
			state_d = gsq_pkg::ST_INIT; // see [RQ8]
			tmr_d = '0;
			armed_d = 1'b0;
		end
		// Removal, re-insertion or a sag below release wins over everything. see [RQ1] see [RQ7]
		if (brown) begin
			state_d = gsq_pkg::ST_RESET;
			tmr_d = '0;
			armed_d = 1'b0;
		end
	end

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			state_q <= gsq_pkg::ST_RESET;
			tmr_q <= '0;
			armed_q <= 1'b0;
			profile_q <= `GSQ_PROFILE_RST;
		end else begin
			state_q <= state_d;
			tmr_q <= tmr_d;
			armed_q <= armed_d;
			profile_q <= profile_d;
		end
	end

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	logic rvalid_q, rvalid_d;
	gsq_pkg::gsq_word_t rdata_q, rdata_d;
	logic [6:0] level;

	always_comb begin
		rvalid_d = REG_RD_I && ready;
		rdata_d = `GSQ_RDATA_NONE;
		if (REG_ADDR_I == `GSQ_OFS_LEVEL) begin
			rdata_d = {9'h000, level};
		end else if (REG_ADDR_I == `GSQ_OFS_PROFILE) begin
			rdata_d = profile_q;
		end else if (REG_ADDR_I == `GSQ_OFS_PWRMODE) begin
			rdata_d = (state_q == gsq_pkg::ST_SLEEP) ? `GSQ_PWR_SLEEP : `GSQ_PWR_OPER;
		end
		if (!rvalid_d) rdata_d = rdata_q;
	end

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rvalid_q <= 1'b0;
			rdata_q <= `GSQ_RDATA_NONE;
		end else begin
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------
	// Measurement, stopped outside operational mode
	// ----------------------------------------
	logic tick;
	gsq_tracker #(
		.FAST_CYC(FAST_CYC),
		.SLOW_CYC(SLOW_CYC)
	) u_tracker (
		.clk_i(CLK_I),
		.nrst_i(NRST_I),
		.run_i(state_q == gsq_pkg::ST_OPER), // see [RQ12]
		.clr_i(state_q == gsq_pkg::ST_INIT),
		.current_i(CELL_CURRENT_I),
		.ocv_level_i(OCV_LEVEL_I),
		.level_o(level),
		.sample_o(tick)
	);
	assign REG_READY_O = ready;
	assign REG_RVALID_O = rvalid_q;
	assign REG_RDATA_O = rdata_q;
	assign IN_RESET_O = state_q == gsq_pkg::ST_RESET;
	assign INIT_BUSY_O = state_q == gsq_pkg::ST_INIT;
	assign OPER_O = state_q == gsq_pkg::ST_OPER;
	assign SLEEP_O = state_q == gsq_pkg::ST_SLEEP;
	assign SAMPLE_O = tick & OPER_O;
	assign CHARGE_LEVEL_O = level;
	assign PROFILE_O = profile_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);

	int init_len_q;
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) init_len_q <= 0;
		else init_len_q <= INIT_BUSY_O ? init_len_q + 1 : 0;
	end

	property p_brownout;
		brown |=> IN_RESET_O;
	endproperty
	a_brownout: assert property (p_brownout) else $error("no reset on low cell"); // see [RQ7]

	property p_release;
		IN_RESET_O && present && above && !insert |=> INIT_BUSY_O;
	endproperty
	a_release: assert property (p_release) else $error("reset not released"); // see [RQ2]

	property p_init_bound;
		INIT_BUSY_O |-> init_len_q < INIT_LIMIT;
	endproperty
	a_init_bound: assert property (p_init_bound) else $error("init too long"); // see [RQ2]

	property p_defaults;
		IN_RESET_O ##1 IN_RESET_O |-> PROFILE_O == `GSQ_PROFILE_RST && !REG_READY_O;
	endproperty
	a_defaults: assert property (p_defaults) else $error("defaults missing"); // see [RQ3]

	property p_no_early_access;
		(IN_RESET_O || INIT_BUSY_O) |-> !REG_READY_O ##1 !REG_RVALID_O;
	endproperty
	a_no_early_access: assert property (p_no_early_access) else $error("early access"); // see [RQ3]

	property p_auto_sleep;
		OPER_O && armed_q && tmr_q == TW'(SLEEP_CYC - 1) && !brown && !wr_ok |=> SLEEP_O;
	endproperty
	a_auto_sleep: assert property (p_auto_sleep) else $error("no auto sleep"); // see [RQ4]

	property p_no_self_sleep;
		!AUTO_SLEEP && !SLEEP_O && !(wr_pwr && REG_WDATA_I == `GSQ_PWR_SLEEP) |=> !SLEEP_O;
	endproperty
	a_no_self_sleep: assert property (p_no_self_sleep) else $error("self sleep"); // see [RQ5]

	property p_profile;
		wr_prof |=> INIT_BUSY_O && PROFILE_O == $past(REG_WDATA_I);
	endproperty
	a_profile: assert property (p_profile) else $error("profile write no init"); // see [RQ8]

	property p_wake;
		SLEEP_O && wr_pwr && !wr_prof && REG_WDATA_I == `GSQ_PWR_OPER |=> OPER_O;
	endproperty
	a_wake: assert property (p_wake) else $error("host wake failed"); // see [RQ11]

	property p_sleep_frozen;
		SLEEP_O ##1 SLEEP_O |-> $stable(CHARGE_LEVEL_O) && !SAMPLE_O;
	endproperty
	a_sleep_frozen: assert property (p_sleep_frozen) else $error("tracking in sleep"); // see [RQ12]

	c_auto_sleep: cover property (OPER_O ##1 SLEEP_O);
	c_reinit: cover property (wr_prof ##1 INIT_BUSY_O);
	c_brownout: cover property (OPER_O && brown ##1 IN_RESET_O);
	c_wake: cover property (SLEEP_O ##1 OPER_O);
endmodule // gsq_sequencer

//--- gsq_host_model.sv
// Host processor model that reaches the sequencer registers
module gsq_host_model (
	// Clock
	input wire logic clk_i,
	// Register port
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] addr_o,
	output logic [15:0] wdata_o,
	input wire logic ready_i,
	input wire logic rvalid_i,
	input wire logic [15:0] rdata_i
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 16'h0000;
	end

	// ----------------------------------------
	// One access: a single-cycle strobe, answer taken one cycle later
	// ----------------------------------------
	task acc(input bit w, input logic [7:0] a, input logic [15:0] d, input int slow,
		output logic [15:0] q, output logic v);
		int n;
		n = 0;
		@(negedge clk_i);
		// Wait up to 1000 cycles before talking to a part that is still resetting or initialising
		while (ready_i !== 1'b1 && n < 1000) begin
			@(negedge clk_i);
			n++;
		end
		repeat (slow) @(negedge clk_i);
		wr_o = w;
		rd_o = !w;
		addr_o = a;
		wdata_o = d;
		@(negedge clk_i);
		q = rdata_i;
		v = rvalid_i;
		wr_o = 1'b0;
		rd_o = 1'b0;
		// Released lines show no stale value
		addr_o = ~a;
		wdata_o = ~d;
	endtask
endmodule // gsq_host_model

//--- gsq_sequencer_tb.sv
// Self-checking testbench of the reset and init sequencer
module gsq_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic CLK_I = 1'b0;
	logic NRST_I, BATT_DET_I, CELL_ABOVE_RR_I, REG_WR_I, REG_RD_I, ramp;
	logic signed [15:0] CELL_CURRENT_I;
	logic [6:0] OCV_LEVEL_I, CHARGE_LEVEL_O;
	logic oper_b, sleep_b;
	logic [7:0] REG_ADDR_I;
	logic [15:0] REG_WDATA_I, REG_RDATA_O, PROFILE_O, q;
	logic REG_READY_O, REG_RVALID_O, IN_RESET_O, INIT_BUSY_O, OPER_O, SLEEP_O, SAMPLE_O, v;
	int miscompares = 0;
	int comparisons = 0;
	int n;

	always #5 CLK_I = ~CLK_I;
	always @(negedge CLK_I) if (ramp) CELL_CURRENT_I <= CELL_CURRENT_I + 16'sh0100;

	// ----------------------------------------
	// Design and host
	// ----------------------------------------
	gsq_sequencer #(.AUTO_SLEEP(1'b1), .INIT_CYC(20), .SLEEP_CYC(50), .FAST_CYC(4),
		.SLOW_CYC(16)) DUT (.CLK_I(CLK_I), .NRST_I(NRST_I), .BATT_DET_I(BATT_DET_I),
		.CELL_ABOVE_RR_I(CELL_ABOVE_RR_I), .CELL_CURRENT_I(CELL_CURRENT_I),
		.OCV_LEVEL_I(OCV_LEVEL_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
		.REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_READY_O(REG_READY_O),
		.REG_RVALID_O(REG_RVALID_O), .REG_RDATA_O(REG_RDATA_O), .IN_RESET_O(IN_RESET_O),
		.INIT_BUSY_O(INIT_BUSY_O), .OPER_O(OPER_O), .SLEEP_O(SLEEP_O),
		.SAMPLE_O(SAMPLE_O), .CHARGE_LEVEL_O(CHARGE_LEVEL_O), .PROFILE_O(PROFILE_O));

	// Fixed variant on the same inputs: it must never fall asleep by itself
	gsq_sequencer #(.AUTO_SLEEP(1'b0), .INIT_CYC(20), .SLEEP_CYC(50), .FAST_CYC(4),
		.SLOW_CYC(16)) DUT_B (.CLK_I(CLK_I), .NRST_I(NRST_I), .BATT_DET_I(BATT_DET_I),
		.CELL_ABOVE_RR_I(CELL_ABOVE_RR_I), .CELL_CURRENT_I(CELL_CURRENT_I),
		.OCV_LEVEL_I(OCV_LEVEL_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
		.REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_READY_O(),
		.REG_RVALID_O(), .REG_RDATA_O(), .IN_RESET_O(), .INIT_BUSY_O(), .OPER_O(oper_b),
		.SLEEP_O(sleep_b), .SAMPLE_O(), .CHARGE_LEVEL_O(), .PROFILE_O());

	gsq_host_model HOST (.clk_i(CLK_I), .wr_o(REG_WR_I), .rd_o(REG_RD_I),
		.addr_o(REG_ADDR_I), .wdata_o(REG_WDATA_I), .ready_i(REG_READY_O),
		.rvalid_i(REG_RVALID_O), .rdata_i(REG_RDATA_O));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		comparisons++;
		if (s !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
			miscompares++;
		end
	endtask

	function automatic logic sig(input int s);
		case (s)
			0: sig = OPER_O;
			1: sig = SLEEP_O;
			2: sig = IN_RESET_O;
			3: sig = SAMPLE_O;
			default: sig = INIT_BUSY_O;
		endcase
	endfunction

	// Cycles until the selected output is seen high, bounded
	task cnt(input int s, output int k);
		k = 0;
		do begin
			@(negedge CLK_I);
			k++;
		end while (sig(s) !== 1'b1 && k < 500);
	endtask

	task end_sim;
		if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_insert;
		BATT_DET_I = 1'b1;
		CELL_ABOVE_RR_I = 1'b1;
		cnt(4, n);
		chk("busy soon", 16'h0001, 16'(n <= 8));
		chk("profile default", 16'h0000, PROFILE_O);
		chk("ready in init", 16'h0000, 16'(REG_READY_O));
		cnt(0, n);
		chk("init cycles", 16'd20, 16'(n));
		chk("level from ocv", 16'h0030, 16'(CHARGE_LEVEL_O));
	endtask

	task t_sleep;
		cnt(1, n);
		chk("auto sleep cycles", 16'd50, 16'(n));
		chk("fixed variant oper", 16'h0001, 16'(oper_b));
		chk("fixed variant sleep", 16'h0000, 16'(sleep_b));
		HOST.acc(1'b0, 8'h15, 16'h0000, 0, q, v);
		chk("mode sleep", 16'h0002, q);
		HOST.acc(1'b0, 8'h0d, 16'h0000, 3, q, v);
		chk("level read valid", 16'h0001, 16'(v));
		chk("level read", 16'h0030, q);
		n = 0;
		repeat (40) @(negedge CLK_I) n += SAMPLE_O;
		chk("samples in sleep", 16'h0000, 16'(n));
		HOST.acc(1'b1, 8'h15, 16'h0003, 0, q, v);
		chk("bad mode ignored", 16'h0001, 16'(SLEEP_O));
		HOST.acc(1'b1, 8'h15, 16'h0001, 0, q, v);
		chk("woken", 16'h0001, 16'(OPER_O));
	endtask

	task t_regs;
		HOST.acc(1'b0, 8'h15, 16'h0000, 0, q, v);
		chk("mode oper", 16'h0001, q);
		HOST.acc(1'b0, 8'h20, 16'h0000, 0, q, v);
		chk("unmapped read", 16'h0000, q);
		HOST.acc(1'b1, 8'h0d, 16'h0055, 0, q, v);
		HOST.acc(1'b0, 8'h0d, 16'h0000, 0, q, v);
		chk("level read only", 16'h0030, q);
	endtask

	task t_sample;
		cnt(3, n);
		cnt(3, n);
		chk("slow interval", 16'd16, 16'(n));
		ramp = 1'b1;
		cnt(3, n);
		cnt(3, n);
		cnt(3, n);
		chk("fast interval", 16'd4, 16'(n));
		ramp = 1'b0;
		chk("no sleep after wake", 16'h0000, 16'(SLEEP_O));
	endtask

	task t_profile;
		HOST.acc(1'b1, 8'h12, 16'h0001, 0, q, v);
		chk("reinit busy", 16'h0001, 16'(INIT_BUSY_O));
		chk("reinit ready", 16'h0000, 16'(REG_READY_O));
		chk("profile value", 16'h0001, PROFILE_O);
		cnt(0, n);
		chk("reinit cycles", 16'd20, 16'(n));
		cnt(1, n);
		chk("resleep cycles", 16'd50, 16'(n));
		chk("fixed variant awake", 16'h0001, 16'(oper_b));
		chk("profile kept", 16'h0001, PROFILE_O);
		HOST.acc(1'b0, 8'h12, 16'h0000, 0, q, v);
		chk("profile read", 16'h0001, q);
	endtask

	task t_brown;
		CELL_ABOVE_RR_I = 1'b0;
		cnt(2, n);
		chk("brown-out reset", 16'h0001, 16'(n <= 8));
		chk("ready in reset", 16'h0000, 16'(REG_READY_O));
		@(negedge CLK_I);
		chk("profile cleared", 16'h0000, PROFILE_O);
		BATT_DET_I = 1'b0;
		repeat (10) @(negedge CLK_I);
		chk("held in reset", 16'h0001, 16'(IN_RESET_O));
		t_insert();
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		NRST_I = 1'b0;
		BATT_DET_I = 1'b0;
		CELL_ABOVE_RR_I = 1'b0;
		CELL_CURRENT_I = 16'sh0000;
		OCV_LEVEL_I = 7'h30;
		ramp = 1'b0;
		repeat (10) @(negedge CLK_I);
		NRST_I = 1'b1;
		t_insert();
		t_sleep();
		t_regs();
		t_sample();
		t_profile();
		t_brown();
		end_sim();
	end

	initial begin
		#50us;
		miscompares++;
		end_sim();
	end
endmodule // gsq_sequencer_tb
